//--- design/brr_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BRR_REGS_SVH
`define BRR_REGS_SVH

`define BRR_OFS_LEVEL 4'h0
`define BRR_OFS_FILTER 4'h1
`define BRR_OFS_FLAGS 4'h2
`define BRR_OFS_STATUS 4'h3
`define BRR_OFS_IRQ_STAT 4'h4
`define BRR_OFS_IRQ_MASK 4'h5
`define BRR_OFS_WDT_CODE 4'h6

`define BRR_LEVEL_ENABLE 8'h5a
`define BRR_LEVEL_DISABLE 8'ha5
`define BRR_LEVEL_POR 8'h5a
`define BRR_WDT_ENABLE 5'h0a
`define BRR_WDT_DISABLE 5'h15
`define BRR_WDT_POR 5'h0a
`define BRR_FILTER_POR 2'h1

`define BRR_FLAG_WDTCFG 0
`define BRR_FLAG_CFGERR 1
`define BRR_FLAG_BROWN 2
`define BRR_STAT_EXPIRY 0
`define BRR_STAT_PDOWN 1

`define BRR_IRQ_BROWN 0
`define BRR_IRQ_CFGERR 1
`define BRR_IRQ_WDTCFG 2
`define BRR_IRQ_WDTTO 3

// Filter widths in slow oscillator periods (upper bound of each range)
`define BRR_FILT_W0 8'd8
`define BRR_FILT_W1 8'd32
`define BRR_FILT_W2 8'd64
`define BRR_FILT_W3 8'd128

`define BRR_SRESET_DEFAULT 16
`define BRR_CORE_RST_LEN 4'h4

`endif

//--- design/brr_pkg.sv
// Types shared by the brown-out reset block
`default_nettype none
package brr_pkg;
  typedef enum logic [1:0] {
    BRR_MODE_FAST,
    BRR_MODE_SLOW,
    BRR_MODE_IDLE,
    BRR_MODE_SLEEP
  } brr_mode_t;
  typedef enum logic [1:0] {
    BRR_RST_NONE,
    BRR_RST_FULL,
    BRR_RST_PCSP
  } brr_rst_t;
endpackage : brr_pkg
`default_nettype wire

//--- design/brr_filter.sv
// Low-supply persistence filter counting slow oscillator ticks
`default_nettype none
`include "brr_regs.svh"
module brr_filter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick,
  input wire logic low_supply,
  input wire logic active,
  input wire logic [1:0] sel,
  output logic fire
);
  import brr_pkg::*;

  logic [7:0] count_reg;
  logic [7:0] limit;

  function automatic logic [7:0] width_of(input logic [1:0] s);
    unique case (s)
      2'h0: width_of = `BRR_FILT_W0;
      2'h1: width_of = `BRR_FILT_W1;
      2'h2: width_of = `BRR_FILT_W2;
      2'h3: width_of = `BRR_FILT_W3;
    endcase
  endfunction : width_of

  assign limit = width_of(sel);

  // Any gap in the low indication restarts the count
  always_ff @(posedge clk_sys) begin
    if (rst || !active || !low_supply) begin
      count_reg <= 8'h00; // [RULE4]
    end else if (tick && count_reg < limit) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  assign fire = active && low_supply && (count_reg >= limit); // [RULE4] [RULE6]

  chk_short_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    fire |-> $past(low_supply) && $past(active)) // [RULE4]
    else $error("filter fired without a sustained low supply");
endmodule : brr_filter
`default_nettype wire

//--- design/brr_reset_ctrl.sv
// Brown-out configuration, reset cause flags and core reset control
// Function
// [RULE1] Level code 5A enables 2.1V detection, A5 disables it.
// [RULE2] Any other level code gives full reset after the soft reset delay.
// [RULE3] A corrupt level code reset reloads the level code to 5A.
// [RULE4] Brown-out reset only after low supply persists past filter time.
// [RULE5] A genuine brown-out reset keeps the level code unchanged.
// [RULE6] Filter select 0..3 gives 8, 32, 64, 128 slow periods; resets to 01.
// [RULE7] Filter register bits 7..2 read as zero.
// [RULE8] Brown-out event flag at bit 2 set by brown-out, cleared by software.
// [RULE9] Config error flag at bit 1 set by bad level code; software clears.
// [RULE10] Reset flag bits 7..3 read as zero.
// [RULE11] Watchdog timeout when running: full reset, expiry set, powerdown kept.
// [RULE12] Watchdog timeout asleep: clear PC and SP, set expiry and powerdown.
// [RULE13] Power-on clears both status flags; running brown-out keeps them.
// [RULE14] Power-on resets PC, interrupts, watchdog, timers, ports and SP.
// [RULE15] Watchdog config error flag at bit 0 set by bad watchdog code.
// [RULE16] Brown-out detection is suspended in sleep or idle.
// [RULE17] Soft reset delay is a parameter counted in slow oscillator cycles.
`default_nettype none
`include "brr_regs.svh"
module brr_reset_ctrl #(
  parameter int SRESET_CYCLES = `BRR_SRESET_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic low_supply_pin,
  input wire logic slow_osc_tick,
  input wire brr_pkg::brr_mode_t cpu_mode,
  input wire logic wdt_timeout,
  output logic core_full_reset,
  output logic core_pcsp_reset,
  output logic brownout_enabled,
  output logic irq
);
  import brr_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic low_meta_reg;
  logic low_sync_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_meta_reg <= 1'b0;
      low_sync_reg <= 1'b0;
    end else begin
      low_meta_reg <= low_supply_pin;
      low_sync_reg <= low_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Registers and bus decode
  // ------------------------------------------------------------
  logic [7:0] level_reg;
  logic [1:0] filter_sel_reg;
  logic [4:0] wdt_code_reg;
  logic flag_brown_reg;
  logic flag_cfgerr_reg;
  logic flag_wdtcfg_reg;
  logic expiry_reg;
  logic pdown_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic ack_reg;
  logic wr_hit;
  logic asleep;
  logic level_bad;
  logic wdt_bad;
  logic brown_fire;
  logic cfg_fire;
  logic wdtcfg_fire;
  logic wdt_run;
  logic wdt_sleep;
  logic [3:0] events;

  function automatic logic wr_at(input logic [3:0] ofs);
    wr_at = avs_write && ack_reg && (avs_address == ofs);
  endfunction : wr_at

  // One wait state: the access completes on the second edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_hit = avs_write && ack_reg;

  // ------------------------------------------------------------
  // Reset source detection
  // ------------------------------------------------------------
  assign asleep = (cpu_mode == BRR_MODE_IDLE) ||
                  (cpu_mode == BRR_MODE_SLEEP);
  assign level_bad = (level_reg != `BRR_LEVEL_ENABLE) &&
                     (level_reg != `BRR_LEVEL_DISABLE); // [RULE2]
  assign wdt_bad = (wdt_code_reg != `BRR_WDT_ENABLE) &&
                   (wdt_code_reg != `BRR_WDT_DISABLE);
  assign brownout_enabled = (level_reg == `BRR_LEVEL_ENABLE) &&
                            !asleep; // [RULE1] [RULE16]

  brr_filter u_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(slow_osc_tick),
    .low_supply(low_sync_reg),
    .active(brownout_enabled),
    .sel(filter_sel_reg),
    .fire(brown_fire)
  );

  // Soft reset delay counters for each corrupted code
  logic [15:0] lvl_dly_reg;
  logic [15:0] wdt_dly_reg;
  always_ff @(posedge clk_sys) begin
    if (rst || !level_bad || cfg_fire) begin
      lvl_dly_reg <= 16'h0000;
    end else if (slow_osc_tick) begin
      lvl_dly_reg <= lvl_dly_reg + 16'h0001; // [RULE17]
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst || !wdt_bad || wdtcfg_fire) begin
      wdt_dly_reg <= 16'h0000;
    end else if (slow_osc_tick) begin
      wdt_dly_reg <= wdt_dly_reg + 16'h0001;
    end
  end
  assign cfg_fire = level_bad &&
    (lvl_dly_reg >= 16'(SRESET_CYCLES)); // [RULE2]
  assign wdtcfg_fire = wdt_bad &&
    (wdt_dly_reg >= 16'(SRESET_CYCLES));
  assign wdt_run = wdt_timeout && !asleep;
  assign wdt_sleep = wdt_timeout && asleep;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_reg <= `BRR_LEVEL_POR;
    end else if (cfg_fire) begin
      level_reg <= `BRR_LEVEL_POR; // [RULE3]
    end else if (wr_at(`BRR_OFS_LEVEL)) begin
      level_reg <= avs_writedata[7:0];
    end
    // A brown-out reset leaves level_reg alone [RULE5]
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      filter_sel_reg <= `BRR_FILTER_POR; // [RULE6]
    end else if (wr_at(`BRR_OFS_FILTER)) begin
      filter_sel_reg <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || wdtcfg_fire) begin
      wdt_code_reg <= `BRR_WDT_POR;
    end else if (wr_at(`BRR_OFS_WDT_CODE)) begin
      wdt_code_reg <= avs_writedata[4:0];
    end
  end

  // ------------------------------------------------------------
  // Reset cause flags: set wins over a software clear
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_brown_reg <= 1'b0;
      flag_cfgerr_reg <= 1'b0;
      flag_wdtcfg_reg <= 1'b0;
    end else begin
      if (brown_fire) begin
        flag_brown_reg <= 1'b1; // [RULE8]
      end else if (wr_at(`BRR_OFS_FLAGS)) begin
        flag_brown_reg <= flag_brown_reg &
          avs_writedata[`BRR_FLAG_BROWN];
      end
      if (level_bad) begin
        flag_cfgerr_reg <= 1'b1; // [RULE9]
      end else if (wr_at(`BRR_OFS_FLAGS)) begin
        flag_cfgerr_reg <= flag_cfgerr_reg &
          avs_writedata[`BRR_FLAG_CFGERR];
      end
      if (wdtcfg_fire) begin
        flag_wdtcfg_reg <= 1'b1; // [RULE15]
      end else if (wr_at(`BRR_OFS_FLAGS)) begin
        flag_wdtcfg_reg <= flag_wdtcfg_reg &
          avs_writedata[`BRR_FLAG_WDTCFG];
      end
    end
  end

  // Status flags: power-on clears, watchdog sets expiry (and powerdown only asleep), brown-out keeps
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      expiry_reg <= 1'b0; // [RULE13]
      pdown_reg <= 1'b0;
    end else if (wdt_sleep) begin
      expiry_reg <= 1'b1; // [RULE12]
      pdown_reg <= 1'b1;
    end else if (wdt_run) begin
      expiry_reg <= 1'b1; // [RULE11]
    end
  end

  // ------------------------------------------------------------
  // Core reset outputs
  // ------------------------------------------------------------
  logic [3:0] full_len_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      full_len_reg <= `BRR_CORE_RST_LEN; // [RULE14]
    end else if (brown_fire || cfg_fire || wdtcfg_fire || wdt_run) begin
      full_len_reg <= `BRR_CORE_RST_LEN; // [RULE2] [RULE4] [RULE11]
    end else if (full_len_reg != 4'h0) begin
      full_len_reg <= full_len_reg - 4'h1;
    end
  end
  assign core_full_reset = (full_len_reg != 4'h0); // [RULE14]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      core_pcsp_reset <= 1'b0;
    end else begin
      core_pcsp_reset <= wdt_sleep; // [RULE12]
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  assign events = {wdt_timeout, wdtcfg_fire, cfg_fire, brown_fire};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_irq
      // One register per bit, so each bit has a single writing process
      logic stat_bit_reg;
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          stat_bit_reg <= 1'b0;
        end else if (events[gi]) begin
          stat_bit_reg <= 1'b1;
        end else if (wr_at(`BRR_OFS_IRQ_STAT) && avs_writedata[gi]) begin
          stat_bit_reg <= 1'b0;
        end
      end
      assign irq_stat_reg[gi] = stat_bit_reg;
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_mask_reg <= 4'h0;
    end else if (wr_at(`BRR_OFS_IRQ_MASK)) begin
      irq_mask_reg <= avs_writedata[3:0];
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      unique case (avs_address)
        `BRR_OFS_LEVEL: avs_readdata <= {24'h00_0000, level_reg};
        `BRR_OFS_FILTER: avs_readdata <= {30'h0, filter_sel_reg}; // [RULE7]
        `BRR_OFS_FLAGS: avs_readdata <= {29'h0, flag_brown_reg,
          flag_cfgerr_reg, flag_wdtcfg_reg}; // [RULE10]
        `BRR_OFS_STATUS: avs_readdata <= {30'h0, pdown_reg, expiry_reg};
        `BRR_OFS_IRQ_STAT: avs_readdata <= {28'h000_0000, irq_stat_reg};
        `BRR_OFS_IRQ_MASK: avs_readdata <= {28'h000_0000, irq_mask_reg};
        `BRR_OFS_WDT_CODE: avs_readdata <= {27'h0, wdt_code_reg};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_bad_level;
    level_bad && cfg_fire;
  endsequence
  sequence s_reload;
    ##1 (level_reg == `BRR_LEVEL_POR) && core_full_reset;
  endsequence

  chk_level_reload: assert property (@(posedge clk_sys) disable iff (rst)
    s_bad_level |-> s_reload) // [RULE3]
    else $error("corrupt level code not reloaded with reset");
  chk_level_enable: assert property (@(posedge clk_sys) disable iff (rst)
    level_reg == `BRR_LEVEL_DISABLE |->
    !brownout_enabled && !brown_fire) // [RULE1]
    else $error("detection active with disable code");
  chk_sleep_suspend: assert property (@(posedge clk_sys) disable iff (rst)
    asleep |-> !brown_fire) // [RULE16]
    else $error("brown-out fired while asleep");
  chk_cfg_delay: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_fire |-> lvl_dly_reg == 16'(SRESET_CYCLES)) // [RULE2]
    else $error("config reset before delay");
  chk_brown_keep: assert property (@(posedge clk_sys) disable iff (rst)
    brown_fire && !cfg_fire && !wr_hit |=> $stable(level_reg)) // [RULE5]
    else $error("level code changed by brown-out");
  chk_brown_flag: assert property (@(posedge clk_sys) disable iff (rst)
    brown_fire |=> flag_brown_reg && core_full_reset) // [RULE8]
    else $error("brown-out flag or reset missing");
  chk_cfg_flag: assert property (@(posedge clk_sys) disable iff (rst)
    level_bad |=> flag_cfgerr_reg) // [RULE9]
    else $error("config error flag not set");
  chk_wdtcfg_flag: assert property (@(posedge clk_sys) disable iff (rst)
    wdtcfg_fire |=> flag_wdtcfg_reg && wdt_code_reg == `BRR_WDT_POR) // [RULE15]
    else $error("watchdog config error not handled");
  chk_wdt_run: assert property (@(posedge clk_sys) disable iff (rst)
    wdt_run |=> expiry_reg && $stable(pdown_reg) && core_full_reset) // [RULE11]
    else $error("running watchdog timeout mishandled");
  chk_wdt_sleep: assert property (@(posedge clk_sys) disable iff (rst)
    wdt_sleep |=> expiry_reg && pdown_reg && core_pcsp_reset) // [RULE12]
    else $error("sleeping watchdog timeout mishandled");
  chk_flags_keep: assert property (@(posedge clk_sys) disable iff (rst)
    !wdt_timeout |=> $stable(expiry_reg) && $stable(pdown_reg)) // [RULE13]
    else $error("status flags changed without watchdog");
  chk_por_reset: assert property (@(posedge clk_sys)
    rst |=> core_full_reset && !expiry_reg && !pdown_reg) // [RULE14]
    else $error("power-on reset effects missing");
  chk_filter_por: assert property (@(posedge clk_sys)
    rst |=> filter_sel_reg == `BRR_FILTER_POR) // [RULE6]
    else $error("filter select power-on value wrong");
  chk_rd_zero: assert property (@(posedge clk_sys) disable iff (rst)
    avs_read && !ack_reg && avs_address == `BRR_OFS_FLAGS
    |=> avs_readdata[31:3] == 29'h0) // [RULE10]
    else $error("unimplemented flag bits not zero");
  chk_rd_filt: assert property (@(posedge clk_sys) disable iff (rst)
    avs_read && !ack_reg && avs_address == `BRR_OFS_FILTER
    |=> avs_readdata[31:2] == 30'h0) // [RULE7]
    else $error("unimplemented filter bits not zero");
endmodule : brr_reset_ctrl
`default_nettype wire

//--- tb/test_brownout_reset_and_reset_flags.sv
// Self-checking bench for the brown-out reset and reset flag block
`default_nettype none
`include "brr_regs.svh"
module test_brownout_reset_and_reset_flags;
  timeunit 1ns;
  timeprecision 100ps;
  import brr_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys;
  logic rst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic low_supply_pin;
  logic slow_osc_tick;
  brr_mode_t cpu_mode;
  logic wdt_timeout;
  logic core_full_reset;
  logic core_pcsp_reset;
  logic brownout_enabled;
  logic irq;
  logic [1:0] tick_div;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  int error_cnt;
  int tests_run;
  int full_cnt;
  int pcsp_cnt;
  int widths[4] = '{8, 32, 64, 128};

  brr_reset_ctrl #(.SRESET_CYCLES(2)) u_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .low_supply_pin(low_supply_pin),
    .slow_osc_tick(slow_osc_tick),
    .cpu_mode(cpu_mode),
    .wdt_timeout(wdt_timeout),
    .core_full_reset(core_full_reset),
    .core_pcsp_reset(core_pcsp_reset),
    .brownout_enabled(brownout_enabled),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // Clock, slow oscillator tick every 4 cycles, output monitors
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    tick_div <= tick_div + 2'd1;
    slow_osc_tick <= (tick_div == 2'd3);
  end

  always @(posedge clk_sys) begin
    if (core_full_reset === 1'b1) full_cnt++;
    if (core_pcsp_reset === 1'b1) pcsp_cnt++;
  end

  // Read data is taken at the edge where the request is accepted
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: read with no expectation", $time);
      end else begin
        check(avs_readdata, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic [3:0] a, input logic wr,
                     input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    // Hold the request until waitrequest is seen low; the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(a, 1'b0, 32'h0000_0000);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic pulse_wdt();
    @(posedge clk_sys);
    wdt_timeout <= 1'b1;
    @(posedge clk_sys);
    wdt_timeout <= 1'b0;
  endtask : pulse_wdt

  task automatic low_for(input int n);
    @(posedge clk_sys);
    low_supply_pin <= 1'b1;
    idle(n);
    low_supply_pin <= 1'b0;
  endtask : low_for

  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    idle(3);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(32'(core_full_reset), 32'h0000_0001);
    idle(8);
  endtask : do_reset

  task automatic give_verdict();
    $display("Comparisons: %0d, mismatches: %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Watchdog for hangs
  // ----------------------------------------------------------------
  initial begin
    idle(50000);
    error_cnt++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    low_supply_pin = 1'b0;
    slow_osc_tick = 1'b0;
    tick_div = 2'h0;
    cpu_mode = BRR_MODE_FAST;
    wdt_timeout = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    full_cnt = 0;
    pcsp_cnt = 0;
    rnd = $urandom(93);
    do_reset();
    // Power-on values, unmapped place, unimplemented bits
    rd(`BRR_OFS_LEVEL, 32'h0000_005a);
    rd(`BRR_OFS_FILTER, 32'h0000_0001);
    rd(`BRR_OFS_FLAGS, 32'h0000_0000);
    rd(`BRR_OFS_STATUS, 32'h0000_0000);
    rd(`BRR_OFS_IRQ_MASK, 32'h0000_0000);
    rd(`BRR_OFS_WDT_CODE, 32'h0000_000a);
    wr(4'h7, 32'hffff_ffff);
    rd(4'h7, 32'h0000_0000);
    rnd = $urandom;
    wr(`BRR_OFS_FILTER, rnd);
    rd(`BRR_OFS_FILTER, {30'h0, rnd[1:0]});
    wr(`BRR_OFS_FLAGS, 32'h0000_00ff);
    rd(`BRR_OFS_FLAGS, 32'h0000_0000);
    // Enable, disable and suspension of detection
    idle(2);
    check(32'(brownout_enabled), 32'h0000_0001);
    cpu_mode <= BRR_MODE_SLEEP;
    idle(2);
    check(32'(brownout_enabled), 32'h0000_0000);
    cpu_mode <= BRR_MODE_IDLE;
    idle(2);
    check(32'(brownout_enabled), 32'h0000_0000);
    cpu_mode <= BRR_MODE_FAST;
    wr(`BRR_OFS_LEVEL, 32'h0000_00a5);
    idle(2);
    check(32'(brownout_enabled), 32'h0000_0000);
    wr(`BRR_OFS_LEVEL, 32'h0000_005a);
    // Watchdog expiry while running, with interrupt raise and mask
    wr(`BRR_OFS_IRQ_STAT, 32'h0000_000f);
    wr(`BRR_OFS_IRQ_MASK, 32'h0000_0008);
    cpu_mode <= BRR_MODE_SLOW;
    full_cnt = 0;
    pulse_wdt();
    idle(4);
    check(32'(irq), 32'h0000_0001);
    idle(10);
    check(32'(full_cnt != 0), 32'h0000_0001);
    rd(`BRR_OFS_STATUS, 32'h0000_0001);
    rd(`BRR_OFS_IRQ_STAT, 32'h0000_0008);
    wr(`BRR_OFS_IRQ_MASK, 32'h0000_0000);
    idle(1);
    check(32'(irq), 32'h0000_0000);
    wr(`BRR_OFS_IRQ_MASK, 32'h0000_0008);
    idle(1);
    check(32'(irq), 32'h0000_0001);
    wr(`BRR_OFS_IRQ_STAT, 32'h0000_0008);
    idle(1);
    check(32'(irq), 32'h0000_0000);
    rd(`BRR_OFS_IRQ_STAT, 32'h0000_0000);
    // Watchdog expiry asleep: only PC and SP cleared
    cpu_mode <= BRR_MODE_SLEEP;
    full_cnt = 0;
    pcsp_cnt = 0;
    pulse_wdt();
    // A long low supply while asleep must not reset the core
    low_for(600);
    idle(10);
    check(32'(pcsp_cnt), 32'h0000_0001);
    check(32'(full_cnt), 32'h0000_0000);
    rd(`BRR_OFS_STATUS, 32'h0000_0003);
    rd(`BRR_OFS_FLAGS, 32'h0000_0000);
    cpu_mode <= BRR_MODE_FAST;
    // Low-supply filter for every width code
    for (int i = 0; i < 4; i++) begin
      wr(`BRR_OFS_FILTER, 32'(i));
      wr(`BRR_OFS_FLAGS, 32'h0000_0000);
      full_cnt = 0;
      low_for((widths[i] - 2) * 4);
      idle(20);
      check(32'(full_cnt), 32'h0000_0000);
      low_for((widths[i] + 3) * 4);
      idle(20);
      check(32'(full_cnt != 0), 32'h0000_0001);
      rd(`BRR_OFS_FLAGS, 32'h0000_0004);
      rd(`BRR_OFS_LEVEL, 32'h0000_005a);
      rd(`BRR_OFS_STATUS, 32'h0000_0003);
    end
    // Corrupt level codes
    repeat (3) begin
      do rnd = {24'h0, 8'($urandom)};
      while (rnd == 32'h0000_005a || rnd == 32'h0000_00a5);
      wr(`BRR_OFS_FLAGS, 32'h0000_0000);
      full_cnt = 0;
      wr(`BRR_OFS_LEVEL, rnd);
      idle(40);
      check(32'(full_cnt != 0), 32'h0000_0001);
      rd(`BRR_OFS_LEVEL, 32'h0000_005a);
      rd(`BRR_OFS_FLAGS, 32'h0000_0002);
      wr(`BRR_OFS_FLAGS, 32'h0000_0000);
      rd(`BRR_OFS_FLAGS, 32'h0000_0000);
    end
    // Watchdog disable code is legal and gives no reset
    full_cnt = 0;
    wr(`BRR_OFS_WDT_CODE, 32'h0000_0015);
    idle(40);
    check(32'(full_cnt), 32'h0000_0000);
    // Corrupt watchdog enable code
    full_cnt = 0;
    wr(`BRR_OFS_WDT_CODE, 32'h0000_0007);
    idle(40);
    check(32'(full_cnt != 0), 32'h0000_0001);
    wr(`BRR_OFS_WDT_CODE, 32'h0000_000a);
    rd(`BRR_OFS_FLAGS, 32'h0000_0001);
    // Second power-on reset clears the status flags
    do_reset();
    rd(`BRR_OFS_STATUS, 32'h0000_0000);
    rd(`BRR_OFS_FLAGS, 32'h0000_0000);
    idle(4);
    give_verdict();
  end
endmodule : test_brownout_reset_and_reset_flags
`default_nettype wire
